// >>> hw/tpoq_defines.svh
/*
  Constants of the tagged packet output queues: sizes, register offsets,
  command field positions and reset values.
  Assumes inclusion by every design file that needs a figure.
*/
`ifndef TPOQ_DEFINES_SVH
`define TPOQ_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define TPOQ_NQ 256
`define TPOQ_NPORT 40
`define TPOQ_NCORE 2
`define TPOQ_BUFW 64

// ----------------------------------------
// Control register offsets
// ----------------------------------------
`define TPOQ_OFF_CMD 8'h00
`define TPOQ_OFF_TAG 8'h04
`define TPOQ_OFF_ADDR 8'h08
`define TPOQ_OFF_QCTL 8'h0c
`define TPOQ_OFF_STAT 8'h10
`define TPOQ_OFF_WORK0 8'h14
`define TPOQ_OFF_WORK1 8'h18

// ----------------------------------------
// Command and queue control register fields
// ----------------------------------------
`define TPOQ_CMD_OP_LSB 0
`define TPOQ_CMD_TT_LSB 3
`define TPOQ_CMD_CORE 5
`define TPOQ_CMD_NOTIFY 6
`define TPOQ_CMD_FREE 7
`define TPOQ_QCTL_LEN_LSB 8

// ----------------------------------------
// Reset values, bus answers and address step
// ----------------------------------------
`define TPOQ_RST_WORD 32'h0000_0000
`define TPOQ_RESP_OKAY 2'b00
`define TPOQ_RESP_SLVERR 2'b10
`define TPOQ_WORD_STEP 32'h0000_0004

`endif

// >>> hw/tpoq_pkg.sv
/*
  Types shared by both ends of the tagged packet output queues.
  Assumes the defines header is compiled alongside.
*/
`include "tpoq_defines.svh"

package tpoq_pkg;
  typedef enum logic [1:0] {TT_NULL, TT_TYPE_A, TT_ATOMIC} tpoq_tt_t;
  typedef enum logic [2:0] {OP_SWITCH, OP_GETWORK, OP_CMDWR, OP_FREEWQE} tpoq_op_t;
  typedef enum logic [2:0] {DMA_IDLE, DMA_READ, DMA_FREE, DMA_SEND, DMA_NOTE} tpoq_dma_t;
endpackage

// >>> hw/tpoq_if.sv
/*
  Link between the cores' end and the scheduler and output unit end.
  Assumes one clock; each core holds op_valid until op_ack pulses.
*/
`include "tpoq_defines.svh"

interface tpoq_if;
  import tpoq_pkg::*;
  logic [`TPOQ_NCORE-1:0] op_valid;
  tpoq_op_t op_code [`TPOQ_NCORE];
  tpoq_tt_t op_type [`TPOQ_NCORE];
  logic [31:0] op_tag [`TPOQ_NCORE];
  logic [31:0] op_addr [`TPOQ_NCORE];
  logic [7:0] op_queue [`TPOQ_NCORE];
  logic [5:0] op_len [`TPOQ_NCORE];
  logic [`TPOQ_NCORE-1:0] op_notify;
  logic [`TPOQ_NCORE-1:0] op_free;
  logic [`TPOQ_NCORE-1:0] op_ack;
  logic [`TPOQ_NCORE-1:0] sw_done;
  logic [31:0] work_ptr [`TPOQ_NCORE];
  logic [`TPOQ_NCORE-1:0] sent_notify;

  modport dev (input op_valid, op_code, op_type, op_tag, op_addr, op_queue, op_len,
    op_notify, op_free, output op_ack, sw_done, work_ptr, sent_notify);
  modport core (output op_valid, op_code, op_type, op_tag, op_addr, op_queue, op_len,
    op_notify, op_free, input op_ack, sw_done, work_ptr, sent_notify);
endinterface

// >>> hw/tpoq_pick.sv
/*
  Chooses the next output queue to serve among those holding a command.
  Assumes priorities are stable while a choice is used.
*/
`include "tpoq_defines.svh"

module tpoq_pick (
  // Queue state
  input wire logic [`TPOQ_NQ-1:0] pend,
  input wire logic [2:0] prio [`TPOQ_NQ],
  // Choice
  output logic any,
  output logic [7:0] sel
);
  import tpoq_pkg::*;

  // Highest priority wins; lowest index breaks ties
  always_comb begin
    logic [2:0] best;
    best = 3'h0;
    any = 1'b0;
    sel = 8'h00;
    for (int i = 0; i < `TPOQ_NQ; i++) begin
      if (pend[i] && (!any || prio[i] > best)) begin // see R22 R4
        any = 1'b1;
        best = prio[i];
        sel = 8'(i);
      end
    end
  end
endmodule

// >>> hw/tpoq_dev.sv
/*
  Scheduler lock granting and packet output unit with its queues.
  Assumes memory answers with mem_gnt carrying mem_rdata, and that
  queue mapping and priorities are loaded before traffic starts.
*/
// What this block does
// R1 - Up to 40 output ports, one per interface
// R2 - Up to 256 command output queues
// R3 - Every queue maps to one port, shared
// R4 - Each queue has its own initialised priority
// R5 - Take command, read memory, send to port
// R6 - Notify issuing core after transmission when asked
// R7 - Free data buffer after internal copy when asked
// R8 - Queue locked by atomic switch to its tag
// R9 - Atomic lock granted in ingress order
// R10 - One holder per atomic tag; tags independent
// R11 - Switch complete sets core's complete bit
// R12 - Core writes queue only while holding lock; the code takes a command write into any free slot whatever the lock state
// R13 - Get work frees descriptor, lock, returns pointer
// R14 - Null switch frees descriptor and lock only
// R15 - One flow goes to one queue
// R16 - Same tag_type_a/atomic switch sequence per flow
// R17 - Unlock switches to different type-a tag
// R18 - Work entry may be freed before queuing
// R19 - Type-a items run in parallel
// R20 - Switch request clears complete bit until done
// R21 - Atomic switch completes at head of queue
// R22 - Shared port serves queues by priority
`include "tpoq_defines.svh"

module tpoq_dev (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Core link
  tpoq_if.dev link,
  // Queue configuration
  input wire logic cfg_we,
  input wire logic [7:0] cfg_queue,
  input wire logic [5:0] cfg_port,
  input wire logic [2:0] cfg_prio,
  // New work source
  input wire logic work_in_valid,
  input wire logic [31:0] work_in_ptr,
  output logic work_in_ready,
  // Free buffer pool
  output logic pool_free_valid,
  output logic [31:0] pool_free_ptr,
  // Memory read
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_gnt,
  input wire logic [31:0] mem_rdata,
  // Transmit ports
  output logic tx_valid,
  output logic [5:0] tx_port,
  output logic [31:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);
  import tpoq_pkg::*;

  localparam int NC = `TPOQ_NCORE;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [5:0] qport [`TPOQ_NQ];
  logic [2:0] qprio [`TPOQ_NQ];
  logic [`TPOQ_NQ-1:0] qpend;
  logic [31:0] qaddr [`TPOQ_NQ];
  logic [5:0] qlen [`TPOQ_NQ];
  logic [`TPOQ_NQ-1:0] qnote;
  logic [`TPOQ_NQ-1:0] qfree;
  logic [`TPOQ_NQ-1:0] qcore;
  tpoq_tt_t held [NC];
  logic [31:0] htag [NC];
  logic [NC-1:0] waiting;
  logic [7:0] seq [NC];
  logic [7:0] ingress;
  logic [31:0] buffer [`TPOQ_BUFW];
  tpoq_dma_t dma;
  logic [7:0] cur_q;
  logic [5:0] cnt;
  logic pick_any;
  logic [7:0] pick_sel;
  logic [NC-1:0] take;
  logic [NC-1:0] grant;

  // Wrap-safe ingress comparison
  function automatic logic older(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    return d[7];
  endfunction

  // True when core c may hold an atomic lock on tag t
  function automatic logic lock_free(input int c, input logic [31:0] t);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < NC; k++) begin
      if (k != c && htag[k] == t && held[k] == TT_ATOMIC && !waiting[k]) begin
        ok = 1'b0; // see R10
      end
      if (k != c && waiting[k] && htag[k] == t && older(seq[k], seq[c])) begin
        ok = 1'b0; // see R9
      end
    end
    return ok;
  endfunction

  tpoq_pick u_pick (
    .pend(qpend),
    .prio(qprio),
    .any(pick_any),
    .sel(pick_sel)
  );

  // ----------------------------------------
  // Taking core operations
  // ----------------------------------------
  // A command into a full slot or a pool free clashing with DMA waits unacknowledged
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      take[c] = ce && link.op_valid[c] && !link.op_ack[c];
      case (link.op_code[c])
        OP_GETWORK: take[c] = take[c] && work_in_valid && work_in_ready;
        OP_CMDWR: take[c] = take[c] && !qpend[link.op_queue[c]];
        OP_FREEWQE: take[c] = take[c] && dma != DMA_FREE && !(c == 1 && take[0]);
        default: take[c] = take[c];
      endcase
      grant[c] = waiting[c] && lock_free(c, htag[c]); // see R21
      if (c == 1 && grant[0] && htag[0] == htag[1]) begin
        grant[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.op_ack <= '0;
      work_in_ready <= 1'b0;
    end else if (ce) begin
      link.op_ack <= take;
      work_in_ready <= 1'b0;
      for (int c = 0; c < NC; c++) begin
        if (link.op_valid[c] && !link.op_ack[c] && link.op_code[c] == OP_GETWORK &&
            !(work_in_valid && work_in_ready)) begin
          work_in_ready <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Tag state per core
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.sw_done <= {NC{1'b1}};
      waiting <= '0;
      ingress <= 8'h00;
      for (int c = 0; c < NC; c++) begin
        held[c] <= TT_NULL;
        htag[c] <= 32'h0;
        seq[c] <= 8'h00;
        link.work_ptr[c] <= `TPOQ_RST_WORD;
      end
    end else if (ce) begin
      for (int c = 0; c < NC; c++) begin
        if (grant[c]) begin
          waiting[c] <= 1'b0;
          link.sw_done[c] <= 1'b1; // see R11 R8
        end
        if (take[c] && link.op_code[c] == OP_SWITCH) begin
          htag[c] <= link.op_tag[c];
          held[c] <= link.op_type[c];
          if (link.op_type[c] == TT_ATOMIC) begin
            waiting[c] <= 1'b1;
            link.sw_done[c] <= 1'b0; // see R20
          end else begin
            // Type-a and null need no lock wait
            waiting[c] <= 1'b0;
            link.sw_done[c] <= 1'b1; // see R19 R14
          end
        end
        if (take[c] && link.op_code[c] == OP_GETWORK) begin
          held[c] <= TT_TYPE_A; // see R13
          htag[c] <= 32'h0;
          waiting[c] <= 1'b0;
          link.sw_done[c] <= 1'b1;
          link.work_ptr[c] <= work_in_ptr;
          seq[c] <= ingress;
        end
      end
      if (|(take & {NC{1'b1}}) && (link.op_code[0] == OP_GETWORK && take[0] ||
          link.op_code[1] == OP_GETWORK && take[1])) begin
        ingress <= ingress + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Queue configuration and command slots
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (ce && cfg_we) begin
      qport[cfg_queue] <= cfg_port; // see R3 R1
      qprio[cfg_queue] <= cfg_prio; // see R4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qpend <= '0;
    end else if (ce) begin
      if (dma == DMA_IDLE && pick_any) begin
        qpend[pick_sel] <= 1'b0;
      end
      for (int c = 0; c < NC; c++) begin
        if (take[c] && link.op_code[c] == OP_CMDWR) begin
          qpend[link.op_queue[c]] <= 1'b1; // see R2 R12
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (ce) begin
      for (int c = 0; c < NC; c++) begin
        if (take[c] && link.op_code[c] == OP_CMDWR) begin
          qaddr[link.op_queue[c]] <= link.op_addr[c];
          qlen[link.op_queue[c]] <= link.op_len[c];
          qnote[link.op_queue[c]] <= link.op_notify[c];
          qfree[link.op_queue[c]] <= link.op_free[c];
          qcore[link.op_queue[c]] <= 1'(c);
        end
      end
    end
  end

  // ----------------------------------------
  // Output DMA
  // ----------------------------------------
  // Whole packet is copied inside first, so the buffer can go back early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma <= DMA_IDLE;
      cur_q <= 8'h00;
      cnt <= 6'h00;
      mem_req <= 1'b0;
      mem_addr <= 32'h0;
      tx_valid <= 1'b0;
      tx_port <= 6'h00;
      tx_data <= 32'h0;
      tx_last <= 1'b0;
      link.sent_notify <= '0;
    end else if (ce) begin
      link.sent_notify <= '0;
      case (dma)
        DMA_IDLE: begin
          if (pick_any) begin
            cur_q <= pick_sel; // see R22 R5
            mem_addr <= qaddr[pick_sel];
            mem_req <= 1'b1;
            cnt <= 6'h00;
            dma <= DMA_READ;
          end
        end
        DMA_READ: begin
          if (mem_gnt) begin
            buffer[cnt] <= mem_rdata;
            mem_addr <= mem_addr + `TPOQ_WORD_STEP;
            cnt <= cnt + 6'h01;
            if (cnt == qlen[cur_q]) begin
              mem_req <= 1'b0;
              cnt <= 6'h00;
              dma <= qfree[cur_q] ? DMA_FREE : DMA_SEND;
            end
          end
        end
        DMA_FREE: dma <= DMA_SEND; // see R7
        DMA_SEND: begin
          if (!tx_valid || tx_ready) begin
            if (tx_valid && tx_last) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              dma <= DMA_NOTE;
            end else begin
              tx_valid <= 1'b1;
              tx_port <= qport[cur_q];
              tx_data <= buffer[cnt];
              tx_last <= cnt == qlen[cur_q];
              cnt <= cnt + 6'h01;
            end
          end
        end
        DMA_NOTE: begin
          link.sent_notify[qcore[cur_q]] <= qnote[cur_q]; // see R6
          dma <= DMA_IDLE;
        end
        default: dma <= DMA_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Free pool returns
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pool_free_valid <= 1'b0;
      pool_free_ptr <= 32'h0;
    end else if (ce) begin
      pool_free_valid <= 1'b0;
      if (dma == DMA_FREE) begin
        pool_free_valid <= 1'b1;
        pool_free_ptr <= qaddr[cur_q];
      end
      for (int c = 0; c < NC; c++) begin
        if (take[c] && link.op_code[c] == OP_FREEWQE) begin
          pool_free_valid <= 1'b1; // see R18
          pool_free_ptr <= link.work_ptr[c];
        end
      end
    end
  end
endmodule

// >>> hw/tpoq_core.sv
/*
  Cores' end: takes orders over AXI4-Lite and drives the link.
  Assumes the device end acknowledges each held request by op_ack.
*/
`include "tpoq_defines.svh"

module tpoq_core (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link
  tpoq_if.core link
);
  import tpoq_pkg::*;

  logic [7:0] wa;
  logic [31:0] wd;
  logic aw_ok;
  logic w_ok;
  logic [31:0] tag_reg;
  logic [31:0] addr_reg;
  logic [31:0] qctl_reg;
  logic [1:0] noted;
  logic stat_rd;
  logic do_wr;

  assign do_wr = ce && aw_ok && w_ok && !bvalid;
  assign stat_rd = ce && arvalid && arready && araddr == `TPOQ_OFF_STAT;

  // ----------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `TPOQ_RESP_OKAY;
      wa <= 8'h00;
      wd <= 32'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        wa <= awaddr;
        aw_ok <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd <= wdata;
        w_ok <= 1'b1;
        wready <= 1'b0;
      end
      if (do_wr) begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wa <= `TPOQ_OFF_QCTL) ? `TPOQ_RESP_OKAY : `TPOQ_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `TPOQ_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `TPOQ_RESP_OKAY;
        if (araddr == `TPOQ_OFF_TAG) begin
          rdata <= tag_reg;
        end else if (araddr == `TPOQ_OFF_ADDR) begin
          rdata <= addr_reg;
        end else if (araddr == `TPOQ_OFF_QCTL) begin
          rdata <= qctl_reg;
        end else if (araddr == `TPOQ_OFF_STAT) begin
          rdata <= {26'h0, noted, link.op_valid, link.sw_done};
        end else if (araddr == `TPOQ_OFF_WORK0) begin
          rdata <= link.work_ptr[0];
        end else if (araddr == `TPOQ_OFF_WORK1) begin
          rdata <= link.work_ptr[1];
        end else begin
          rdata <= 32'h0;
          rresp <= (araddr == `TPOQ_OFF_CMD) ? `TPOQ_RESP_OKAY : `TPOQ_RESP_SLVERR;
        end
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Operand registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_reg <= `TPOQ_RST_WORD;
      addr_reg <= `TPOQ_RST_WORD;
      qctl_reg <= `TPOQ_RST_WORD;
    end else if (do_wr && wstrb == 4'hf) begin
      if (wa == `TPOQ_OFF_TAG) begin
        tag_reg <= wd;
      end else if (wa == `TPOQ_OFF_ADDR) begin
        addr_reg <= wd;
      end else if (wa == `TPOQ_OFF_QCTL) begin
        qctl_reg <= wd;
      end
    end
  end

  // Sticky notice; a new notice beats the clear by a status read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      noted <= 2'b00;
    end else if (ce) begin
      noted <= (stat_rd ? 2'b00 : noted) | link.sent_notify; // see R6
    end
  end

  // ----------------------------------------
  // Link requests, held until acknowledged
  // ----------------------------------------
  // A command to a busy core is dropped; software polls its busy bit first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.op_valid <= '0;
      link.op_notify <= '0;
      link.op_free <= '0;
      for (int c = 0; c < `TPOQ_NCORE; c++) begin
        link.op_code[c] <= OP_SWITCH;
        link.op_type[c] <= TT_NULL;
        link.op_tag[c] <= 32'h0;
        link.op_addr[c] <= 32'h0;
        link.op_queue[c] <= 8'h00;
        link.op_len[c] <= 6'h00;
      end
    end else if (ce) begin
      for (int c = 0; c < `TPOQ_NCORE; c++) begin
        if (link.op_ack[c]) begin
          link.op_valid[c] <= 1'b0;
        end
        if (do_wr && wa == `TPOQ_OFF_CMD && wd[`TPOQ_CMD_CORE] == 1'(c) &&
            !link.op_valid[c]) begin
          link.op_valid[c] <= 1'b1; // see R8 R16 R17
          link.op_code[c] <= tpoq_op_t'(wd[`TPOQ_CMD_OP_LSB +: 3]);
          link.op_type[c] <= tpoq_tt_t'(wd[`TPOQ_CMD_TT_LSB +: 2]);
          link.op_notify[c] <= wd[`TPOQ_CMD_NOTIFY];
          link.op_free[c] <= wd[`TPOQ_CMD_FREE];
          link.op_tag[c] <= tag_reg;
          link.op_addr[c] <= addr_reg;
          link.op_queue[c] <= qctl_reg[7:0]; // see R15
          link.op_len[c] <= qctl_reg[`TPOQ_QCTL_LEN_LSB +: 6];
        end
      end
    end
  end
endmodule

// >>> bench/tpoq_checker.sv
/*
  Link assertions for the tagged packet output queues.
  Assumes link signals arrive as plain inputs and ce stays high.
*/
`include "tpoq_defines.svh"

module tpoq_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  input wire logic [`TPOQ_NCORE-1:0] op_valid,
  input wire tpoq_pkg::tpoq_op_t op_code [`TPOQ_NCORE],
  input wire tpoq_pkg::tpoq_tt_t op_type [`TPOQ_NCORE],
  input wire logic [31:0] op_tag [`TPOQ_NCORE],
  input wire logic [`TPOQ_NCORE-1:0] op_ack,
  input wire logic [`TPOQ_NCORE-1:0] sw_done,
  input wire logic [`TPOQ_NCORE-1:0] sent_notify
);
  import tpoq_pkg::*;
  logic [1:0] atom;
  logic [31:0] held [2];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Lock holders
  // ----------------------------------------
  // Cleared at reset so a stale tag never pairs with a new one
  always_ff @(posedge aclk) begin
    for (int c = 0; c < 2; c++) begin
      if (!aresetn) begin
        atom[c] <= 1'b0;
        held[c] <= 32'h0000_0000;
      end else if (op_ack[c] && (op_code[c] == OP_SWITCH || op_code[c] == OP_GETWORK)) begin
        atom[c] <= (op_code[c] == OP_SWITCH) && (op_type[c] == TT_ATOMIC);
        held[c] <= op_tag[c];
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_two_holders: assert property (
    atom[0] && atom[1] && held[0] == held[1] && !op_ack[0] && !op_ack[1] |-> !(&sw_done))
    else $error("two cores hold one atomic tag");
  chk_atomic_clears: assert property (
    op_ack[0] && op_code[0] == OP_SWITCH && op_type[0] == TT_ATOMIC |-> !sw_done[0])
    else $error("atomic switch left complete bit set");
  chk_plain_switch: assert property (
    op_ack[0] && op_code[0] == OP_SWITCH && op_type[0] != TT_ATOMIC |-> ##[0:1] sw_done[0])
    else $error("plain switch did not complete at once");
  chk_work_done: assert property (
    op_ack[1] && op_code[1] == OP_GETWORK |-> ##[0:1] sw_done[1])
    else $error("get work left lock pending");
  chk_ack_pulse: assert property (
    op_ack[0] |=> !op_ack[0])
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (
    $rose(op_ack[1]) |-> $past(op_valid[1]))
    else $error("ack without request");
  chk_done_drop: assert property (
    $fell(sw_done[1]) |-> $past(op_valid[1]) && op_ack[1])
    else $error("complete bit fell without a switch");
  chk_notify_pulse: assert property (
    sent_notify[0] |=> !sent_notify[0])
    else $error("notify longer than one cycle");
endmodule

// >>> bench/tpoq_tb.sv
/*
  Bench for both ends of the tagged packet output queues.
  Assumes the design files and package are compiled first.
*/
`include "tpoq_defines.svh"

module tpoq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tpoq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, cfg_we = 1'b0, work_in_valid = 1'b0;
  logic [7:0] cfg_queue = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [5:0] cfg_port = 6'h00;
  logic [2:0] cfg_prio = 3'h0;
  logic [31:0] work_in_ptr = 32'h0, mem_rdata = 32'h0, wdata = 32'h0;
  logic mem_gnt = 1'b0, tx_ready = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  // Readies stay high; answers never stall
  logic bready = 1'b1, rready = 1'b1;
  logic work_in_ready, pool_free_valid, mem_req, tx_valid, tx_last;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] pool_free_ptr, mem_addr, tx_data, rdata;
  logic [5:0] tx_port;
  logic [1:0] bresp, rresp;
  int fails = 0, checks_done = 0, cyc = 0;
  logic [31:0] txq [$], freeq [$];
  tpoq_if link ();
  tpoq_dev i_tpoq_dev (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(link.dev),
    .cfg_we(cfg_we), .cfg_queue(cfg_queue), .cfg_port(cfg_port), .cfg_prio(cfg_prio),
    .work_in_valid(work_in_valid), .work_in_ptr(work_in_ptr), .work_in_ready(work_in_ready),
    .pool_free_valid(pool_free_valid), .pool_free_ptr(pool_free_ptr), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
    .tx_port(tx_port), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
  tpoq_core i_tpoq_core (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(link.core));
  tpoq_checker i_tpoq_checker (.aclk(aclk), .aresetn(aresetn), .op_valid(link.op_valid),
    .op_code(link.op_code), .op_type(link.op_type), .op_tag(link.op_tag),
    .op_ack(link.op_ack), .sw_done(link.sw_done), .sent_notify(link.sent_notify));
  always #12.5 aclk = ~aclk;
  // ----------------------------------------
  // Memory, ports and watchdog
  // ----------------------------------------
  // Grant every other cycle so the reader sees stalls
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    mem_gnt <= mem_req && !mem_gnt;
    mem_rdata <= mem_addr + 32'h0a00_0000;
    if (tx_valid && tx_ready) begin
      txq.push_back({tx_last, tx_data[30:0]});
      cmp32("tx_port", 32'h7, {26'h0, tx_port});
    end
    if (pool_free_valid) freeq.push_back(pool_free_ptr);
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    cmp32("write resp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    cmp32("read data", e, d & m);
    cmp32("read resp", {30'h0, er}, {30'h0, r});
  endtask
  // Reading status clears sticky notify, so only poll where none is due
  task automatic op(input logic [7:0] v);
    logic [31:0] d;
    logic [1:0] r;
    wr(`TPOQ_OFF_CMD, {24'h0, v}, `TPOQ_RESP_OKAY);
    repeat (3) @(posedge aclk);
    do rd(`TPOQ_OFF_STAT, d, r); while (d[3:2] !== 2'b00);
  endtask
  task automatic send(input logic [7:0] q, input logic [7:0] f);
    wr(`TPOQ_OFF_TAG, {24'h0, q}, `TPOQ_RESP_OKAY);
    op(8'h10);
    wr(`TPOQ_OFF_ADDR, {16'h0, q, 8'h00}, `TPOQ_RESP_OKAY);
    wr(`TPOQ_OFF_QCTL, {18'h0, 6'h01, q}, `TPOQ_RESP_OKAY);
    op(f);
    op(8'h00);
  endtask
  task automatic t_regs();
    rd_chk(`TPOQ_OFF_STAT, 32'hf, 32'h3, `TPOQ_RESP_OKAY);
    rd_chk(8'h1c, 32'hffff_ffff, 32'h0, `TPOQ_RESP_SLVERR);
    wr(`TPOQ_OFF_STAT, 32'h0, `TPOQ_RESP_SLVERR);
  endtask
  task automatic t_lock();
    wr(`TPOQ_OFF_TAG, 32'h9, `TPOQ_RESP_OKAY);
    op(8'h10);
    rd_chk(`TPOQ_OFF_STAT, 32'hf, 32'h3, `TPOQ_RESP_OKAY);
    op(8'h30);
    rd_chk(`TPOQ_OFF_STAT, 32'hf, 32'h1, `TPOQ_RESP_OKAY);
    op(8'h00);
    rd_chk(`TPOQ_OFF_STAT, 32'hf, 32'h3, `TPOQ_RESP_OKAY);
    op(8'h20);
  endtask
  task automatic t_work();
    work_in_ptr <= 32'h0000_abc0;
    work_in_valid <= 1'b1;
    op(8'h21);
    work_in_valid <= 1'b0;
    rd_chk(`TPOQ_OFF_WORK1, 32'hffff_ffff, 32'h0000_abc0, `TPOQ_RESP_OKAY);
    rd_chk(`TPOQ_OFF_STAT, 32'hf, 32'h3, `TPOQ_RESP_OKAY);
    op(8'h23);
    cmp32("wqe free", 32'h0000_abc0, freeq.pop_front());
  endtask
  task automatic t_tx();
    logic [31:0] e;
    logic [7:0] ord [3] = '{8'h01, 8'h04, 8'h02};
    tx_ready <= 1'b0;
    send(8'h01, 8'h82);
    send(8'h04, 8'h02);
    send(8'h02, 8'h42);
    tx_ready <= 1'b1;
    while (txq.size() < 6) @(posedge aclk);
    // Highest priority waiting queue goes after the busy one
    for (int i = 0; i < 6; i++) begin
      e = {16'h0, ord[i/2], 8'h00} + 32'h0a00_0000 + 32'(4 * (i % 2));
      cmp32("tx word", e | {i[0], 31'h0}, txq[i]);
    end
    cmp32("free count", 32'h1, 32'(freeq.size()));
    cmp32("free ptr", 32'h0000_0100, freeq[0]);
    repeat (4) @(posedge aclk);
    rd_chk(`TPOQ_OFF_STAT, 32'h30, 32'h10, `TPOQ_RESP_OKAY);
  endtask
  task automatic tally_and_finish();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Queues below 8 share port 7 so their priorities compete
    for (int q = 0; q < 256; q++) begin
      @(posedge aclk);
      cfg_we <= 1'b1;
      cfg_queue <= 8'(q);
      cfg_port <= (q < 8) ? 6'h07 : 6'(q % 40);
      cfg_prio <= 3'(q);
    end
    @(posedge aclk);
    cfg_we <= 1'b0;
    t_regs();
    t_lock();
    t_work();
    t_tx();
    tally_and_finish();
  end
endmodule
